// ---- verilog/bcr_defs.svh ----
// Offsets, indexes, reset values and field positions of the bus configuration bank
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH
`define BCR_IDX_W          5
`define BCR_IDX_MSRD       5'h00
`define BCR_IDX_MSWR       5'h01
`define BCR_IDX_MISC       5'h02
`define BCR_IDX_RSV3       5'h03
`define BCR_IDX_LNK        5'h04
`define BCR_IDX_IND1       5'h05
`define BCR_IDX_IND2       5'h06
`define BCR_IDX_IND3       5'h07
`define BCR_IDX_IOBL       5'h10
`define BCR_IDX_IOBU       5'h11
`define BCR_IDX_BURST      5'h12
`define BCR_IDX_CMEM       5'h13
`define BCR_IDX_SWST       5'h14
`define BCR_IDX_INTC       5'h15
`define BCR_IDX_LAST       5'h15
`define BCR_RST_MSRD       16'h0005
`define BCR_RST_MSWR       16'h0005
`define BCR_RST_LNK        16'h00c0
`define BCR_RST_IND1       16'h0084
`define BCR_RST_IND2       16'h0088
`define BCR_RST_IND3       16'h0090
`define BCR_RST_BURST      16'h2101
`define BCR_RST_CMEM       16'h0002
`define BCR_RST_SWST       16'h0000
`define BCR_UNDEF_READ     16'h0000
`define BCR_SHADOW_HI      4
`define BCR_SHADOW_LO      3
`define BCR_SHADOW_VALID   15
`define BCR_SHADOW_SERIAL  2'h2
`define BCR_SHADOW_NORMAL  2'h0
`define BCR_RUNT_MIN_BYTES 16'h0040
`define BCR_SERIAL_ADDR_W  24
`endif

// ---- verilog/bcr_pkg.sv ----
// Types shared by the bus configuration bank
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_MODE_NORMAL   = 2'b00,
    BCR_MODE_SERIAL   = 2'b01,
    BCR_MODE_RESERVED = 2'b10
  } bcr_mode_type;
  typedef enum logic [1:0] {
    BCR_SRC_USER = 2'b00,
    BCR_SRC_CMEM = 2'b01,
    BCR_SRC_RELO = 2'b10
  } bcr_src_type;
endpackage : bcr_pkg

// ---- verilog/bcr_mode_if.sv ----
// Mode decision passed from the register file to the pin mux
`timescale 1ns/1ps
`default_nettype none
interface bcr_mode_if;
  import bcr_pkg::*;
  bcr_mode_type mode;
  modport src (output mode);
  modport dst (input mode);
endinterface : bcr_mode_if
`default_nettype wire

// ---- verilog/bcr_mode_sel.sv ----
// Operating mode decision from shadow code, shadow valid and enable bit
`timescale 1ns/1ps
`default_nettype none
`include "bcr_defs.svh"
module bcr_mode_sel
  import bcr_pkg::*;
(
  input  wire logic [1:0] shadowModeCode,
  input  wire logic       shadowValid,
  input  wire logic       serialPortEnable,
  bcr_mode_if.src         modeOut
);
  always_comb
  begin
    if (!shadowValid)
      modeOut.mode = serialPortEnable ? BCR_MODE_SERIAL : BCR_MODE_NORMAL;
    else if (shadowModeCode == `BCR_SHADOW_SERIAL)
      modeOut.mode = BCR_MODE_SERIAL;
    else if (shadowModeCode == `BCR_SHADOW_NORMAL && !serialPortEnable)
      modeOut.mode = BCR_MODE_NORMAL;
    else
      modeOut.mode = BCR_MODE_RESERVED;
  end
endmodule : bcr_mode_sel
`default_nettype wire

// ---- verilog/bcr_pin_mux.sv ----
// Address pin remap between normal bus use and the serial network port
`timescale 1ns/1ps
`default_nettype none
module bcr_pin_mux
  import bcr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  bcr_mode_if.dst          modeIn,
  input  wire logic [31:0] masterAddr,
  input  wire logic        masterAddrDrive,
  input  wire logic        serialTxData,
  input  wire logic        serialTxEnable,
  input  wire logic [31:0] addrPinIn,
  output logic      [31:0] addrPinOut,
  output logic      [31:0] addrPinOe,
  output logic             serialTxClock,
  output logic             serialCollision,
  output logic             serialCarrierSense,
  output logic             serialRxClock,
  output logic             serialRxData
);
  logic [4:0] syncOne;
  logic [4:0] syncTwo;
  logic [4:0] next_syncOne;
  logic [4:0] next_syncTwo;
  logic       serialOn;
  assign serialOn = (modeIn.mode == BCR_MODE_SERIAL);
  always_comb
  begin
    next_syncOne = addrPinIn[29:25];
    next_syncTwo = syncOne;
    if (srst)
    begin
      next_syncOne = 5'h00;
      next_syncTwo = 5'h00;
    end
  end
  always_ff @(posedge mclk)
  begin
    syncOne <= next_syncOne;
    syncTwo <= next_syncTwo;
  end
  // Inputs read as idle outside serial mode so the receiver sees no activity
  assign serialTxClock      = serialOn & syncTwo[4];
  assign serialCollision    = serialOn & syncTwo[3];
  assign serialCarrierSense = serialOn & syncTwo[2];
  assign serialRxClock      = serialOn & syncTwo[1];
  assign serialRxData       = serialOn & syncTwo[0];
  always_comb
  begin
    addrPinOut = masterAddr;
    addrPinOe  = {32{masterAddrDrive}};
    if (serialOn)
    begin
      addrPinOut[31:24] = {serialTxData, serialTxEnable, 6'h00};
      addrPinOe[31:24]  = 8'hc0;
    end
  end
  serial_pins_a: assert property (@(posedge mclk) disable iff (srst)
    serialOn |-> addrPinOe[29:24] == 6'h00 && addrPinOut[31] == serialTxData)
    else $error("serial port pins misdriven");
  upper_addr_a: assert property (@(posedge mclk) disable iff (srst)
    serialOn && masterAddrDrive |-> addrPinOut[29:24] == 6'h00)
    else $error("upper address carries data in serial mode");
endmodule : bcr_pin_mux
`default_nettype wire

// ---- verilog/bcr_bank.sv ----
// Bus configuration register bank with index and data ports
`timescale 1ns/1ps
`default_nettype none
`include "bcr_defs.svh"
module bcr_bank
  import bcr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        softReset,
  input  wire logic        stopBit,
  input  wire logic        doublewordIoMode,
  input  wire logic        indexWrite,
  input  wire logic [31:0] indexWdata,
  input  wire logic        dataWrite,
  input  wire logic        dataRead,
  input  wire logic [31:0] dataWdata,
  output logic      [31:0] dataRdata,
  output logic      [4:0]  registerIndexPort,
  input  wire logic        cmemWrite,
  input  wire logic        reloWrite,
  input  wire logic [4:0]  loadIndex,
  input  wire logic [15:0] loadData,
  input  wire logic        testEnable,
  input  wire logic        runtWrite,
  input  wire logic        runtWdata,
  output logic             runtAccept,
  input  wire logic        serialPortEnable,
  input  wire logic        frameDone,
  input  wire logic [15:0] frameBytes,
  output logic             frameAccept,
  output logic [1:0]       operatingMode,
  input  wire logic [31:0] masterAddr,
  input  wire logic        masterAddrDrive,
  input  wire logic        serialTxData,
  input  wire logic        serialTxEnable,
  input  wire logic [31:0] addrPinIn,
  output logic      [31:0] addrPinOut,
  output logic      [31:0] addrPinOe,
  output logic             serialTxClock,
  output logic             serialCollision,
  output logic             serialCarrierSense,
  output logic             serialRxClock,
  output logic             serialRxData
);
  localparam int NREG = 22;
  logic [15:0] regs [NREG];
  logic [15:0] next_regs [NREG];
  logic [4:0]  next_registerIndexPort;
  logic        next_runtAccept;
  logic [31:0] next_dataRdata;
  logic        next_frameAccept;
  logic        userOk [NREG];
  logic        cmemOk [NREG];
  logic        reloOk [NREG];
  bcr_mode_if  modeBus ();

  // Write permission per index by source
  always_comb
  begin
    for (int i = 0; i < NREG; i++)
    begin
      userOk[i] = 1'b0;
      cmemOk[i] = 1'b0;
      reloOk[i] = 1'b0;
    end
    for (int i = 4; i <= 7; i++)
      userOk[i] = 1'b1;
    for (int i = 19; i <= 20; i++)
      userOk[i] = 1'b1;
    userOk[2]  = 1'b1;
    userOk[16] = 1'b1;
    userOk[17] = 1'b1;
    userOk[18] = 1'b1;
    userOk[21] = 1'b1;
    cmemOk[2]  = 1'b1;
    cmemOk[16] = 1'b1;
    cmemOk[17] = 1'b1;
    cmemOk[18] = 1'b1;
    cmemOk[21] = 1'b1;
    reloOk[2]  = 1'b1;
    reloOk[16] = 1'b1;
    reloOk[17] = 1'b1;
    reloOk[21] = 1'b1;
  end

  always_comb
  begin
    next_registerIndexPort = registerIndexPort;
    if (indexWrite)
      next_registerIndexPort = indexWdata[4:0];
    for (int i = 0; i < NREG; i++)
    begin
      next_regs[i] = regs[i];
      if (dataWrite && registerIndexPort == i[4:0] && userOk[i])
        next_regs[i] = dataWdata[15:0];
      else if (cmemWrite && loadIndex == i[4:0] && cmemOk[i])
        next_regs[i] = loadData;
      else if (reloWrite && loadIndex == i[4:0] && reloOk[i])
        next_regs[i] = loadData;
    end
    next_runtAccept = runtAccept;
    if (runtWrite && testEnable)
      next_runtAccept = runtWdata;
    next_dataRdata = dataRdata;
    if (dataRead)
    begin
      next_dataRdata = 32'h00000000;
      if (registerIndexPort <= `BCR_IDX_LAST)
        next_dataRdata[15:0] = regs[registerIndexPort];
    end
    next_frameAccept = 1'b0;
    if (frameDone)
      next_frameAccept = runtAccept || frameBytes >= `BCR_RUNT_MIN_BYTES;
    // Soft reset and stop are deliberately not looked at here
    if (srst)
    begin
      next_registerIndexPort = 5'h00;
      for (int i = 0; i < NREG; i++)
        next_regs[i] = `BCR_UNDEF_READ;
      next_regs[0]  = `BCR_RST_MSRD;
      next_regs[1]  = `BCR_RST_MSWR;
      next_regs[4]  = `BCR_RST_LNK;
      next_regs[5]  = `BCR_RST_IND1;
      next_regs[6]  = `BCR_RST_IND2;
      next_regs[7]  = `BCR_RST_IND3;
      next_regs[18] = `BCR_RST_BURST;
      next_regs[19] = `BCR_RST_CMEM;
      next_regs[20] = `BCR_RST_SWST;
      next_runtAccept  = 1'b0;
      next_dataRdata   = 32'h00000000;
      next_frameAccept = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    registerIndexPort <= next_registerIndexPort;
    regs              <= next_regs;
    runtAccept        <= next_runtAccept;
    dataRdata         <= next_dataRdata;
    frameAccept       <= next_frameAccept;
  end

  bcr_mode_sel uModeSel (
    .shadowModeCode   (regs[18][`BCR_SHADOW_HI:`BCR_SHADOW_LO]),
    .shadowValid      (regs[19][`BCR_SHADOW_VALID]),
    .serialPortEnable (serialPortEnable),
    .modeOut          (modeBus)
  );
  assign operatingMode = modeBus.mode;

  bcr_pin_mux uPinMux (
    .mclk               (mclk),
    .srst               (srst),
    .modeIn             (modeBus),
    .masterAddr         (masterAddr),
    .masterAddrDrive    (masterAddrDrive),
    .serialTxData       (serialTxData),
    .serialTxEnable     (serialTxEnable),
    .addrPinIn          (addrPinIn),
    .addrPinOut         (addrPinOut),
    .addrPinOe          (addrPinOe),
    .serialTxClock      (serialTxClock),
    .serialCollision    (serialCollision),
    .serialCarrierSense (serialCarrierSense),
    .serialRxClock      (serialRxClock),
    .serialRxData       (serialRxData)
  );

  // Antecedents also test the sampled reset: a one-cycle reset is already released
  // when the attempt on its edge starts, so the reset itself would look like a change
  read_active_a: assert property (@(posedge mclk) disable iff (srst)
    regs[0] == `BCR_RST_MSRD && regs[1] == `BCR_RST_MSWR)
    else $error("master active register changed");
  reserved_write_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && dataWrite && registerIndexPort == `BCR_IDX_RSV3 |=> $stable(regs[3]))
    else $error("reserved index took a write");
  user_write_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && dataWrite && registerIndexPort == `BCR_IDX_LNK
    |=> regs[4] == $past(dataWdata[15:0]))
    else $error("user write lost");
  burst_relo_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && reloWrite && !dataWrite && !cmemWrite && loadIndex == `BCR_IDX_BURST
    |=> $stable(regs[18]))
    else $error("relocation wrote burst register");
  runt_guard_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && !testEnable |=> $stable(runtAccept))
    else $error("runt bit changed outside test mode");
  runt_hold_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && runtAccept && !(runtWrite && testEnable && !runtWdata) |=> runtAccept)
    else $error("runt accept dropped");
  runt_frame_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && frameDone && runtAccept |=> frameAccept)
    else $error("runt frame rejected in accept mode");
  soft_keep_a: assert property (@(posedge mclk) disable iff (srst)
    !srst && (softReset || stopBit) && !dataWrite && !cmemWrite && !reloWrite
    |=> $stable(regs[20]) && $stable(regs[4]))
    else $error("soft reset disturbed bank");
  hard_default_a: assert property (@(posedge mclk)
    srst |=> regs[18] == `BCR_RST_BURST && regs[5] == `BCR_RST_IND1)
    else $error("hard reset default wrong");
  upper_zero_a: assert property (@(posedge mclk) disable iff (srst)
    dataRead |=> dataRdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  serial_mode_a: assert property (@(posedge mclk) disable iff (srst)
    regs[19][15] && regs[18][4:3] == 2'h2 |-> operatingMode == BCR_MODE_SERIAL)
    else $error("shadow serial mode not selected");
  runt_seq_c: cover property (@(posedge mclk) disable iff (srst)
    testEnable ##1 runtWrite && testEnable && runtWdata ##1 !testEnable ##1 runtAccept);
  serial_c: cover property (@(posedge mclk) disable iff (srst)
    operatingMode == BCR_MODE_SERIAL);
  load_c: cover property (@(posedge mclk) disable iff (srst)
    cmemWrite && loadIndex == `BCR_IDX_IOBL);
  read_c: cover property (@(posedge mclk) disable iff (srst)
    indexWrite ##1 dataRead);
endmodule : bcr_bank
`default_nettype wire

// ---- sim/bcr_host_model.sv ----
// Host processor model: slave accesses through the index port and the data port
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model
(
  input  wire logic        mclk,
  input  wire logic [31:0] dataRdata,
  output logic             indexWrite,
  output logic [31:0]      indexWdata,
  output logic             dataWrite,
  output logic             dataRead,
  output logic [31:0]      dataWdata
);
  initial
  begin
    {indexWrite, dataWrite, dataRead} = 3'h0;
    indexWdata = 32'h0000_0000;
    dataWdata  = 32'h0000_0000;
  end
  // Idle data lines are inverted so a stale value never passes for a fresh one
  task set_index(input logic [4:0] idx);
    @(posedge mclk);
    indexWrite <= 1'b1;
    indexWdata <= {27'h0, idx};
    @(posedge mclk);
    indexWrite <= 1'b0;
    indexWdata <= ~indexWdata;
  endtask : set_index
  task data_write(input logic [31:0] d);
    @(posedge mclk);
    dataWrite <= 1'b1;
    dataWdata <= d;
    @(posedge mclk);
    dataWrite <= 1'b0;
    dataWdata <= ~d;
  endtask : data_write
  task data_read(output logic [31:0] v);
    @(posedge mclk);
    dataRead <= 1'b1;
    @(posedge mclk);
    dataRead <= 1'b0;
    @(posedge mclk);
    #1;
    v = dataRdata;
  endtask : data_read
endmodule : bcr_host_model
`default_nettype wire

// ---- sim/bus_config_register_bank_tb.sv ----
// Self-checking bench for the bus configuration register bank
`timescale 1ns/1ps
`default_nettype none
module bus_config_register_bank_tb;
  import bcr_pkg::*;
  logic        mclk, srst, softReset, stopBit, doublewordIoMode, cmemWrite, reloWrite;
  logic        testEnable, runtWrite, runtWdata, serialPortEnable, frameDone;
  logic        masterAddrDrive, serialTxData, serialTxEnable;
  logic [4:0]  loadIndex;
  logic [15:0] loadData, frameBytes;
  logic [31:0] masterAddr, addrPinIn, dataRdata, indexWdata, dataWdata, addrPinOut, addrPinOe;
  logic        indexWrite, dataWrite, dataRead, runtAccept, frameAccept;
  logic        serialTxClock, serialCollision, serialCarrierSense, serialRxClock, serialRxData;
  logic [4:0]  registerIndexPort;
  logic [1:0]  operatingMode;
  int          numErrors, checksDone;
  logic [31:0] v;
  logic [21:0] r;
  logic [5:0]  m;
  // Rows: writable, index, value after hard reset (undefined ones read 0)
  logic [21:0] regRows [18] = '{
    {1'b0, 5'h00, 16'h0005}, {1'b0, 5'h01, 16'h0005}, {1'b1, 5'h02, 16'h0000},
    {1'b0, 5'h03, 16'h0000}, {1'b1, 5'h04, 16'h00c0}, {1'b1, 5'h05, 16'h0084},
    {1'b1, 5'h06, 16'h0088}, {1'b1, 5'h07, 16'h0090}, {1'b0, 5'h08, 16'h0000},
    {1'b0, 5'h0f, 16'h0000}, {1'b1, 5'h10, 16'h0000}, {1'b1, 5'h11, 16'h0000},
    {1'b1, 5'h12, 16'h2101}, {1'b1, 5'h13, 16'h0002}, {1'b1, 5'h14, 16'h0000},
    {1'b1, 5'h15, 16'h0000}, {1'b0, 5'h16, 16'h0000}, {1'b0, 5'h1f, 16'h0000}};
  // Rows: from config memory, index, value read back after the load
  logic [21:0] loadRows [8] = '{
    {1'b1, 5'h02, 16'hc302}, {1'b1, 5'h04, 16'h00c0}, {1'b0, 5'h12, 16'h2101},
    {1'b1, 5'h12, 16'hc312}, {1'b1, 5'h13, 16'h0002}, {1'b0, 5'h10, 16'hc310},
    {1'b0, 5'h15, 16'hc315}, {1'b1, 5'h00, 16'h0005}};
  // Rows: shadow code, shadow valid, serial enable, expected mode
  logic [5:0]  modeRows [8] = '{6'b00_0_0_00, 6'b10_1_0_01, 6'b10_1_1_01, 6'b01_1_0_10,
                               6'b11_1_1_10, 6'b10_0_0_00, 6'b11_0_1_01, 6'b00_1_1_10};

  bcr_bank dut_u (.mclk, .srst, .softReset, .stopBit, .doublewordIoMode, .indexWrite,
    .indexWdata, .dataWrite, .dataRead, .dataWdata, .dataRdata, .registerIndexPort,
    .cmemWrite, .reloWrite, .loadIndex, .loadData, .testEnable, .runtWrite, .runtWdata,
    .runtAccept, .serialPortEnable, .frameDone, .frameBytes, .frameAccept, .operatingMode,
    .masterAddr, .masterAddrDrive, .serialTxData, .serialTxEnable, .addrPinIn, .addrPinOut,
    .addrPinOe, .serialTxClock, .serialCollision, .serialCarrierSense, .serialRxClock,
    .serialRxData);
  bcr_host_model host_u (.mclk, .dataRdata, .indexWrite, .indexWdata, .dataWrite,
    .dataRead, .dataWdata);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task report_and_stop;
    if (numErrors == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #500000;
    numErrors++;
    report_and_stop();
  end

  task chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      numErrors++;
    end
  endtask : chk_reg
  task chk_flag(input string what, input logic exp, input logic got);
    checksDone++;
    if (got !== exp)
    begin
      $display("BAD %s expected %b seen %b", what, exp, got);
      numErrors++;
    end
  endtask : chk_flag
  task wr(input logic [4:0] idx, input logic [31:0] d);
    host_u.set_index(idx);
    host_u.data_write(d);
  endtask : wr
  task rd(input logic [4:0] idx, output logic [31:0] d);
    host_u.set_index(idx);
    host_u.data_read(d);
    chk_reg("index", {27'h0, idx}, {27'h0, registerIndexPort});
  endtask : rd
  task check_defaults;
    foreach (regRows[i])
    begin
      rd(regRows[i][20:16], v);
      chk_reg("default", {16'h0, regRows[i][15:0]}, v);
    end
  endtask : check_defaults
  task runt_set(input logic b);
    @(posedge mclk);
    runtWrite <= 1'b1;
    runtWdata <= b;
    @(posedge mclk);
    runtWrite <= 1'b0;
    runtWdata <= ~b;
    #1;
  endtask : runt_set
  task frame(input logic [15:0] n, input logic exp);
    @(posedge mclk);
    frameDone  <= 1'b1;
    frameBytes <= n;
    @(posedge mclk);
    frameDone <= 1'b0;
    #1;
    chk_flag("frame accept", exp, frameAccept);
  endtask : frame

  initial
  begin
    numErrors = 0;
    checksDone = 0;
    {srst, softReset, stopBit, doublewordIoMode, cmemWrite, reloWrite} = 6'h20;
    {testEnable, runtWrite, runtWdata, serialPortEnable, frameDone} = 5'h00;
    {masterAddrDrive, serialTxData, serialTxEnable} = 3'h0;
    {loadIndex, loadData, frameBytes} = 37'h0;
    {masterAddr, addrPinIn} = 64'h0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    doublewordIoMode <= 1'b1;
    check_defaults();
    foreach (regRows[i])
    begin
      r = regRows[i];
      wr(r[20:16], {16'h0, r[20:16], 11'h05a});
      rd(r[20:16], v);
      chk_reg("after write", r[21] ? {16'h0, r[20:16], 11'h05a} : {16'h0, r[15:0]}, v);
    end
    // Upper half written with ones on purpose: it must be dropped
    wr(5'h04, 32'hffff_1234);
    rd(5'h04, v);
    chk_reg("upper half", 32'h0000_1234, v);
    doublewordIoMode <= 1'b0;
    rd(5'h04, v);
    chk_reg("word mode", 32'h0000_1234, v);
    doublewordIoMode <= 1'b1;
    host_u.set_index(5'h05);
    host_u.data_write(32'h0000_0a5a);
    host_u.data_write(32'h0000_5a0a);
    host_u.data_read(v);
    chk_reg("kept index", 32'h0000_5a0a, v);
    foreach (modeRows[i])
    begin
      m = modeRows[i];
      wr(5'h12, {16'h0, 11'h108, m[5:4], 3'h1});
      wr(5'h13, {16'h0, m[3], 15'h0002});
      serialPortEnable <= m[2];
      @(posedge mclk);
      #1;
      chk_reg("mode", {30'h0, m[1:0]}, {30'h0, operatingMode});
    end
    wr(5'h12, 32'h0000_2101);
    wr(5'h13, 32'h0000_0002);
    masterAddrDrive <= 1'b1;
    masterAddr <= 32'hc35a_96e1;
    for (int i = 0; i < 3; i++)
    begin
      serialPortEnable <= (i < 2);
      {serialTxData, serialTxEnable} <= i[0] ? 2'b01 : 2'b10;
      addrPinIn <= {2'b11, (i[0] ? 5'b01001 : 5'b10110), 25'h0};
      repeat (4) @(posedge mclk);
      #1;
      v = {27'h0, serialTxClock, serialCollision, serialCarrierSense, serialRxClock, serialRxData};
      if (i < 2)
      begin
        chk_reg("serial in", {27'h0, (i[0] ? 5'b01001 : 5'b10110)}, v);
        chk_reg("pins out", {(i[0] ? 2'b01 : 2'b10), 6'h0, 24'h5a96e1},
                {addrPinOut[31:30], addrPinOut[29:24], addrPinOut[23:0]});
        chk_reg("pin enables", 32'hc0ff_ffff, addrPinOe);
      end
      else
      begin
        chk_reg("serial in", 32'h0, v);
        chk_reg("pins out", 32'hc35a_96e1, addrPinOut);
        chk_reg("pin enables", 32'hffff_ffff, addrPinOe);
      end
    end
    runt_set(1'b1);
    chk_flag("runt", 1'b0, runtAccept);
    frame(16'd63, 1'b0);
    frame(16'd64, 1'b1);
    testEnable <= 1'b1;
    runt_set(1'b1);
    testEnable <= 1'b0;
    chk_flag("runt", 1'b1, runtAccept);
    frame(16'd63, 1'b1);
    runt_set(1'b0);
    chk_flag("runt", 1'b1, runtAccept);
    frame(16'd1, 1'b1);
    testEnable <= 1'b1;
    runt_set(1'b0);
    chk_flag("runt", 1'b0, runtAccept);
    runt_set(1'b1);
    testEnable <= 1'b0;
    {softReset, stopBit} <= 2'b11;
    repeat (3) @(posedge mclk);
    {softReset, stopBit} <= 2'b00;
    rd(5'h05, v);
    chk_reg("soft reset", 32'h0000_5a0a, v);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk_flag("runt", 1'b0, runtAccept);
    check_defaults();
    foreach (loadRows[i])
    begin
      r = loadRows[i];
      @(posedge mclk);
      {cmemWrite, reloWrite} <= {r[21], ~r[21]};
      loadIndex <= r[20:16];
      loadData <= {11'h618, r[20:16]};
      @(posedge mclk);
      {cmemWrite, reloWrite} <= 2'b00;
      loadData <= 16'h0000;
      rd(r[20:16], v);
      chk_reg("load", {16'h0, r[15:0]}, v);
    end
    report_and_stop();
  end
endmodule : bus_config_register_bank_tb
`default_nettype wire
